// file: design/cpu_regs_pkg.sv
package cpu_regs_pkg;

    // ----------------------------------------
    // Register file and space layout
    // ----------------------------------------
    localparam int unsigned NUM_REGS     = 32;
    localparam int unsigned REG_AW       = 5;
    localparam int unsigned DATA_AW      = 16;
    localparam int unsigned IO_AW        = 6;
    localparam int unsigned IO_BASE      = 32;
    localparam int unsigned IO_COUNT     = 64;
    localparam logic [4:0]  PTR_X_LO     = 5'd26;
    localparam logic [4:0]  PTR_Y_LO     = 5'd28;
    localparam logic [4:0]  PTR_Z_LO     = 5'd30;
    localparam logic [5:0]  IO_STATUS    = 6'h3F;
    localparam int unsigned NUM_IRQ      = 8;

    // ----------------------------------------
    // Status flag bit positions
    // ----------------------------------------
    localparam int unsigned FLAG_I = 7;
    localparam int unsigned FLAG_T = 6;
    localparam int unsigned FLAG_H = 5;
    localparam int unsigned FLAG_S = 4;
    localparam int unsigned FLAG_V = 3;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_C = 0;
    localparam logic [7:0]  STATUS_RESET = 8'h00;

    // ----------------------------------------
    // APB register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFS_STATUS  = 8'h00;
    localparam logic [7:0] OFS_CTRL    = 8'h04;
    localparam logic [7:0] OFS_IRQ     = 8'h08;
    localparam logic [7:0] OFS_PTRXY   = 8'h0C;
    localparam logic [7:0] OFS_PTRZ    = 8'h10;
    localparam logic [7:0] OFS_REGBASE = 8'h80;

    // ----------------------------------------
    // Write-back schemes and interrupt states
    // ----------------------------------------
    typedef enum logic [1:0] {
        WB_NONE  = 2'b00,
        WB_BYTE  = 2'b01,
        WB_WORD  = 2'b11
    } wb_mode_t;

    typedef enum logic [1:0] {
        IRQ_RUN    = 2'b00,
        IRQ_ENTER  = 2'b01,
        IRQ_HOLD   = 2'b11
    } irq_state_t;

    // Flag update request from the ALU.
    typedef struct packed {
        logic [7:0] mask;
        logic       h;
        logic       v;
        logic       c;
    } flag_upd_t;

    // Decoded operation from the instruction decoder.
    typedef struct packed {
        logic [4:0] rd;
        logic [4:0] rr;
        wb_mode_t   wb;
        logic [15:0] wdata;
        logic       bit_store_op;
        logic       bit_load_op;
        logic [2:0] bitsel;
        logic       sei;
        logic       cli;
        logic       return_from_interrupt_op;
    } dec_op_t;

endpackage

// file: design/cpu_status_and_register_file.sv
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
module cpu_status_and_register_file
    import cpu_regs_pkg::*;
#(
    parameter int unsigned PROG_AW    = 14,            // Program word address width.
    parameter logic [13:0] BOOT_START = 14'h3000       // First word of boot area.
) (
    input  wire logic                pclk,             // Clock.
    input  wire logic                presetn,          // Async reset, active low.
    input  wire logic                clk_en,           // Freezes all state when low.
    input  wire logic                psel,             // APB select.
    input  wire logic                penable,          // APB enable.
    input  wire logic                pwrite,           // APB direction.
    input  wire logic [7:0]          paddr,            // APB byte address.
    input  wire logic [31:0]         pwdata,           // APB write data.
    output logic      [31:0]         prdata,           // APB read data.
    output logic                     pready,           // APB ready.
    output logic                     pslverr,          // APB error on unmapped.
    input  wire dec_op_t             op,               // Decoded operation.
    input  wire logic                op_valid,         // Operation executes this cycle.
    input  wire logic [7:0]          alu_res,          // Byte ALU result.
    input  wire flag_upd_t           alu_flags,        // Flag update from ALU.
    input  wire logic                alu_valid,        // ALU result valid.
    output logic      [7:0]          rd_data,          // Operand A (byte).
    output logic      [7:0]          rr_data,          // Operand B (byte).
    output logic      [15:0]         rd_word,          // Operand pair read.
    output logic      [15:0]         ptr_x,            // X pointer.
    output logic      [15:0]         ptr_y,            // Y pointer.
    output logic      [15:0]         ptr_z,            // Z pointer, also table address.
    input  wire logic [DATA_AW-1:0]  dmem_addr,        // Data space address.
    input  wire logic                dmem_we,          // Data space write.
    input  wire logic [7:0]          dmem_wdata,       // Data space write data.
    output logic      [7:0]          dmem_rdata,       // Data space read data.
    output logic                     dmem_is_reg,      // Address hits register file.
    output logic                     io_sel,           // Address hits I/O space.
    output logic      [IO_AW-1:0]    io_addr,          // I/O address.
    input  wire logic [7:0]          io_rdata,         // Peripheral read data.
    input  wire logic [NUM_IRQ-1:0]  irq_req,          // Interrupt requests.
    input  wire logic [NUM_IRQ-1:0]  irq_en,           // Individual enables.
    input  wire logic                insn_done,        // One instruction retired.
    output logic                     irq_take,         // Interrupt accepted (pulse).
    output logic      [2:0]          irq_vec,          // Accepted vector index.
    input  wire logic [PROG_AW-1:0]  pc,               // Current program counter.
    input  wire logic [15:0]         fetch_word,       // Program memory word.
    output logic      [15:0]         insn_ff,          // Prefetched instruction.
    output logic      [15:0]         ret_addr,         // Return address to push.
    output logic                     push_ret,         // Push return address pulse.
    input  wire logic                call_op,          // Subroutine call.
    input  wire logic                store_program_memory_op, // Program store request.
    input  wire logic [PROG_AW-1:0]  spm_target,       // Program store target.
    output logic                     spm_allow,        // Program store permitted.
    output logic      [7:0]          status_flags      // Status flags.
);

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [7:0]  regs_ff [NUM_REGS];
    logic [7:0]  flags_ff;
    irq_state_t  irq_st_ff;
    logic [7:0]  ctrl_ff;
    logic        apb_wr;
    logic        apb_reg_hit;
    logic [4:0]  apb_idx;
    logic        irq_allowed;
    logic [NUM_IRQ-1:0] pend;
    logic [2:0]  win;

    assign status_flags = flags_ff;
    assign apb_wr       = psel && penable && pwrite && clk_en;
    assign apb_reg_hit  = paddr[7];
    assign apb_idx      = paddr[6:2];

    // Register file writes: decoder byte or pair, data space, bit load, APB.
    generate
        for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    regs_ff[i] <= 8'h00;
                end else if (clk_en) begin
                    if (op_valid && op.wb == WB_WORD && op.rd[4:1] == i[4:1]) begin
                        regs_ff[i] <= i[0] ? op.wdata[15:8] : op.wdata[7:0];
                    end else if (op_valid && op.wb == WB_BYTE && op.rd == i[4:0]) begin
                        regs_ff[i] <= alu_valid ? alu_res : op.wdata[7:0];
                    end else if (op_valid && op.bit_load_op && op.rd == i[4:0]) begin
                        regs_ff[i][op.bitsel] <= flags_ff[FLAG_T];
                    end else if (dmem_we && dmem_addr == 16'(i)) begin
                        regs_ff[i] <= dmem_wdata;
                    end else if (apb_wr && apb_reg_hit && apb_idx == i[4:0]) begin
                        regs_ff[i] <= pwdata[7:0];
                    end
                end
            end
        end
    endgenerate

    // Combinational operand reads give single-cycle access.
    assign rd_data = regs_ff[op.rd];
    assign rr_data = regs_ff[op.rr];
    assign rd_word = {regs_ff[{op.rd[4:1], 1'b1}], regs_ff[{op.rd[4:1], 1'b0}]};

    // Pointers are adjacent pairs at the top of the file, low byte first.
    assign ptr_x = {regs_ff[PTR_X_LO + 5'd1], regs_ff[PTR_X_LO]};
    assign ptr_y = {regs_ff[PTR_Y_LO + 5'd1], regs_ff[PTR_Y_LO]};
    assign ptr_z = {regs_ff[PTR_Z_LO + 5'd1], regs_ff[PTR_Z_LO]};

    // ----------------------------------------
    // Data space decode
    // ----------------------------------------
    // Registers occupy the first locations, I/O follows.
    always_comb begin
        dmem_is_reg = dmem_addr < 16'(IO_BASE);
        io_sel      = !dmem_is_reg && dmem_addr < 16'(IO_BASE + IO_COUNT);
        io_addr     = 6'(dmem_addr - 16'(IO_BASE));
        if (dmem_is_reg) begin
            dmem_rdata = regs_ff[dmem_addr[4:0]];
        end else if (io_sel && io_addr == IO_STATUS) begin
            dmem_rdata = flags_ff;
        end else if (io_sel) begin
            dmem_rdata = io_rdata;
        end else begin
            dmem_rdata = 8'h00;
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    // Interrupt bit, copy bit, then ALU flags; sign is always N xor V.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= STATUS_RESET;
        end else if (clk_en) begin
            if (apb_wr && !apb_reg_hit && paddr == OFS_STATUS) begin
                flags_ff <= {pwdata[7:5], pwdata[2] ^ pwdata[3], pwdata[3:0]};
            end else if (dmem_we && io_sel && io_addr == IO_STATUS) begin
                flags_ff <= {dmem_wdata[7:5], dmem_wdata[2] ^ dmem_wdata[3], dmem_wdata[3:0]};
            end else begin
                if (irq_take || (op_valid && op.cli)) begin
                    flags_ff[FLAG_I] <= 1'b0;
                end else if (op_valid && (op.sei || op.return_from_interrupt_op)) begin
                    flags_ff[FLAG_I] <= 1'b1;
                end
                if (op_valid && op.bit_store_op) begin
                    flags_ff[FLAG_T] <= regs_ff[op.rd][op.bitsel];
                end
                if (alu_valid) begin
                    if (alu_flags.mask[FLAG_H]) flags_ff[FLAG_H] <= alu_flags.h;
                    if (alu_flags.mask[FLAG_V]) flags_ff[FLAG_V] <= alu_flags.v;
                    if (alu_flags.mask[FLAG_N]) flags_ff[FLAG_N] <= alu_res[7];
                    if (alu_flags.mask[FLAG_Z]) flags_ff[FLAG_Z] <= alu_res == 8'h00;
                    if (alu_flags.mask[FLAG_C]) flags_ff[FLAG_C] <= alu_flags.c;
                    flags_ff[FLAG_S] <= (alu_flags.mask[FLAG_N] ? alu_res[7] : flags_ff[FLAG_N])
                        ^ (alu_flags.mask[FLAG_V] ? alu_flags.v : flags_ff[FLAG_V]);
                end
            end
        end
    end

    // ----------------------------------------
    // Interrupt acceptance
    // ----------------------------------------
    // Lowest index wins among enabled pending requests.
    assign pend = irq_req & irq_en;
    always_comb begin
        win = 3'd0;
        for (int k = NUM_IRQ - 1; k >= 0; k--) begin
            if (pend[k]) win = 3'(k);
        end
    end

    // After a return, hold off until one more instruction retires.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_ff <= IRQ_RUN;
        end else if (clk_en) begin
            case (irq_st_ff)
                IRQ_RUN:   irq_st_ff <= irq_take ? IRQ_ENTER : IRQ_RUN;
                IRQ_ENTER: irq_st_ff <= (op_valid && op.return_from_interrupt_op) ? IRQ_HOLD : IRQ_ENTER;
                IRQ_HOLD:  irq_st_ff <= insn_done ? IRQ_RUN : IRQ_HOLD;
                default:   irq_st_ff <= IRQ_RUN;
            endcase
        end
    end

    // Status is never saved here; the handler preserves it itself.
    assign irq_allowed = flags_ff[FLAG_I] && irq_st_ff != IRQ_HOLD
                         && !(op_valid && op.cli);
    assign irq_take    = clk_en && irq_allowed && insn_done && (|pend);
    assign irq_vec     = win;

    // Return address pushed to the stack on call or interrupt.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ret_addr <= 16'h0000;
            push_ret <= 1'b0;
        end else if (clk_en) begin
            push_ret <= irq_take || call_op;
            ret_addr <= 16'(pc);
        end
    end

    // ----------------------------------------
    // Prefetch and program store guard
    // ----------------------------------------
    // Next word latched every cycle while the current one executes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            insn_ff <= 16'h0000;
        end else if (clk_en) begin
            insn_ff <= fetch_word;
        end
    end

    assign spm_allow = store_program_memory_op
                       && (spm_target >= BOOT_START || pc >= BOOT_START);

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // Scratch control byte, zero-wait reads.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= 8'h00;
        end else if (apb_wr && !apb_reg_hit && paddr == OFS_CTRL) begin
            ctrl_ff <= pwdata[7:0];
        end
    end

    assign pready = 1'b1;
    always_comb begin
        pslverr = 1'b0;
        prdata  = 32'h0000_0000;
        if (apb_reg_hit) begin
            prdata = {24'h00_0000, regs_ff[apb_idx]};
        end else begin
            case (paddr)
                OFS_STATUS: prdata = {24'h00_0000, flags_ff};
                OFS_CTRL:   prdata = {24'h00_0000, ctrl_ff};
                OFS_IRQ:    prdata = {14'h0000, irq_st_ff, 13'h0000, irq_vec};
                OFS_PTRXY:  prdata = {ptr_y, ptr_x};
                OFS_PTRZ:   prdata = {16'h0000, ptr_z};
                default:    pslverr = psel && penable;
            endcase
        end
    end

endmodule // cpu_status_and_register_file

// file: testbench/cpu_regs_checker_asserts.sv
`timescale 1ns/1ps
// Watches the register file, flags and interrupt gate from the top ports.
module cpu_regs_checker
    import cpu_regs_pkg::*;
#(
    parameter int unsigned PROG_AW    = 14,       // Program word address width.
    parameter logic [13:0] BOOT_START = 14'h3000  // First word of boot area.
) (
    input wire logic               pclk,          // Clock.
    input wire logic               presetn,       // Reset, active low.
    input wire logic               clk_en,        // State enable.
    input wire logic               psel,          // Bus select.
    input wire logic               penable,       // Bus enable.
    input wire logic               pwrite,        // Bus direction.
    input wire dec_op_t            op,            // Decoded operation.
    input wire logic               op_valid,      // Operation valid.
    input wire logic [15:0]        rd_word,       // Pair read.
    input wire logic [15:0]        ptr_z,         // Z pointer.
    input wire logic [DATA_AW-1:0] dmem_addr,     // Data space address.
    input wire logic               dmem_we,       // Data space write.
    input wire logic               dmem_is_reg,   // Register hit.
    input wire logic               io_sel,        // I/O hit.
    input wire logic               insn_done,     // Instruction retired.
    input wire logic               irq_take,      // Interrupt accepted.
    input wire logic               push_ret,      // Push pulse.
    input wire logic               call_op,       // Subroutine call.
    input wire logic [PROG_AW-1:0] pc,            // Program counter.
    input wire logic               store_program_memory_op, // Program store.
    input wire logic [PROG_AW-1:0] spm_target,    // Store target.
    input wire logic               spm_allow,     // Store permitted.
    input wire logic [7:0]         status_flags   // Status flags.
);
    // Any bus or data space write that may overwrite the flags.
    logic flag_wr;
    assign flag_wr = (psel && penable && pwrite) || dmem_we;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_reset_clear; $rose(presetn) |-> status_flags == 8'h00; endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("flags not clear");
    property p_sign; status_flags[4] == (status_flags[2] ^ status_flags[3]); endproperty
    a_sign: assert property (p_sign) else $error("sign flag wrong");
    property p_gate; irq_take |-> status_flags[7]; endproperty
    a_gate: assert property (p_gate) else $error("take while disabled");
    property p_take_clear; irq_take && clk_en && !flag_wr && !op_valid |=> !status_flags[7];
    endproperty
    a_take_clear: assert property (p_take_clear) else $error("enable kept");
    property p_return_from_interrupt_op_set; op_valid && op.return_from_interrupt_op && !op.cli && clk_en && !flag_wr |=> status_flags[7];
    endproperty
    a_return_from_interrupt_op_set: assert property (p_return_from_interrupt_op_set) else $error("enable not set");
    property p_cli_block; op_valid && op.cli |-> !irq_take; endproperty
    a_cli_block: assert property (p_cli_block) else $error("take during clear");
    property p_push; (irq_take || call_op) && clk_en |=> push_ret; endproperty
    a_push: assert property (p_push) else $error("no return push");
    property p_ptr; op.rd == PTR_Z_LO |-> rd_word == ptr_z; endproperty
    a_ptr: assert property (p_ptr) else $error("pointer pair wrong");
    property p_map; (dmem_is_reg == (dmem_addr < 16'd32))
        && (io_sel == (dmem_addr >= 16'd32 && dmem_addr < 16'd96)); endproperty
    a_map: assert property (p_map) else $error("space decode wrong");
    property p_spm; store_program_memory_op && spm_target < BOOT_START && pc < BOOT_START
        |-> !spm_allow; endproperty
    a_spm: assert property (p_spm) else $error("store allowed");
    property p_hold; op_valid && op.return_from_interrupt_op && clk_en && !insn_done |=> !irq_take; endproperty
    a_hold: assert property (p_hold) else $error("take after return");
endmodule // cpu_regs_checker

bind cpu_status_and_register_file cpu_regs_checker #(.PROG_AW(PROG_AW),
    .BOOT_START(BOOT_START)) u_chk (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .op, .op_valid, .rd_word, .ptr_z, .dmem_addr, .dmem_we, .dmem_is_reg, .io_sel,
    .insn_done, .irq_take, .push_ret, .call_op, .pc, .store_program_memory_op,
    .spm_target, .spm_allow, .status_flags);

// file: testbench/alu_model.sv
`timescale 1ns/1ps
// Stand-in ALU: adds the two operands and reports the byte-add flags.
module alu_model
    import cpu_regs_pkg::*;
(
    input  wire logic [7:0] a_in,    // Operand A.
    input  wire logic [7:0] b_in,    // Operand B.
    input  wire logic       add_en,  // Add this cycle.
    output logic      [7:0] res,     // Sum.
    output flag_upd_t       flg,     // Flag update.
    output logic            vld      // Result valid.
);
    logic [8:0] sum;

    // Byte add with carry out, low nibble carry and signed overflow.
    always_comb begin
        sum = {1'b0, a_in} + {1'b0, b_in};
        res = sum[7:0];
        vld = add_en;
        flg.mask = 8'h3F;
        flg.c = sum[8];
        flg.h = (a_in[3] & b_in[3]) | (b_in[3] & ~sum[3]) | (~sum[3] & a_in[3]);
        flg.v = (a_in[7] & b_in[7] & ~sum[7]) | (~a_in[7] & ~b_in[7] & sum[7]);
    end
endmodule // alu_model

// file: testbench/test_cpu_status_and_register_file.sv
`timescale 1ns/1ps
module test_cpu_status_and_register_file
    import cpu_regs_pkg::*;
;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr, alu_res, rd_data, rr_data, dmem_wdata, dmem_rdata, status_flags;
    logic [31:0] pwdata, prdata, q;
    dec_op_t o, op;
    flag_upd_t alu_flags;
    logic op_valid, alu_valid, add_en, dmem_we, dmem_is_reg, io_sel, insn_done;
    logic irq_take, push_ret, call_op, store_program_memory_op, spm_allow;
    logic [15:0] rd_word, ptr_x, ptr_y, ptr_z, dmem_addr, fetch_word, insn_ff, ret_addr;
    logic [5:0] io_addr;
    logic [7:0] irq_req, irq_en;
    logic [2:0] irq_vec;
    logic [13:0] pc, spm_target;
    logic [7:0] av[4] = '{8'h7F, 8'hFF, 8'h0F, 8'h80};
    logic [7:0] bv[4] = '{8'h01, 8'h01, 8'h01, 8'h80};
    int mismatches, check_count;

    cpu_status_and_register_file dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .op, .op_valid, .alu_res, .alu_flags,
        .alu_valid, .rd_data, .rr_data, .rd_word, .ptr_x, .ptr_y, .ptr_z, .dmem_addr,
        .dmem_we, .dmem_wdata, .dmem_rdata, .dmem_is_reg, .io_sel, .io_addr, .io_rdata(8'h00),
        .irq_req, .irq_en, .insn_done, .irq_take, .irq_vec, .pc, .fetch_word, .insn_ff,
        .ret_addr, .push_ret, .call_op, .store_program_memory_op, .spm_target, .spm_allow,
        .status_flags);
    alu_model u_alu (.a_in(rd_data), .b_in(rr_data), .add_en, .res(alu_res),
        .flg(alu_flags), .vld(alu_valid));

    // Free-running bus clock.
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask
    task automatic exec(input dec_op_t x, input logic add);
        @(posedge pclk);
        op <= x;
        op_valid <= 1'b1;
        add_en <= add;
        @(posedge pclk);
        op_valid <= 1'b0;
        add_en <= 1'b0;
        #1;
    endtask
    task automatic dm(input logic [15:0] a, input logic w, input logic [7:0] d);
        @(posedge pclk);
        dmem_addr <= a;
        dmem_we <= w;
        dmem_wdata <= d;
        @(posedge pclk);
        dmem_we <= 1'b0;
        #1;
    endtask
    task automatic step(input logic exp);
        @(posedge pclk);
        insn_done <= 1'b1;
        #1;
        chk({irq_take, irq_vec}, {exp, 3'd1});
        @(posedge pclk);
        insn_done <= 1'b0;
        #1;
        if (exp) chk({push_ret, status_flags[7]}, 2'b10);
    endtask
    function automatic logic [7:0] exp_add(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        logic h, v;
        s = a + b;
        h = (a[3:0] + b[3:0]) > 5'd15;
        v = (a[7] == b[7]) && (s[7] != a[7]);
        return {2'b00, h, s[7] ^ v, v, s[7], s[7:0] == 8'h00, s[8]};
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog that cuts a hang short.
    initial begin
        repeat (3000) @(posedge pclk);
        mismatches++;
        end_sim();
    end

    // Main sequence of tests.
    initial begin
        {presetn, clk_en, psel, penable, pwrite, paddr, pwdata} = '0;
        {op, op_valid, add_en, dmem_addr, dmem_we, dmem_wdata, insn_done, call_op} = '0;
        {store_program_memory_op, pc, spm_target} = '0;
        {irq_req, irq_en, fetch_word} = {8'h06, 8'hFF, 16'hA5C3};
        clk_en = 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1 chk(status_flags, 8'h00);
        rd(OFS_STATUS, 32'h0000_0000);
        for (int i = 26; i < 32; i++) apb(1'b1, 8'h80 + 8'(4 * i), 32'(i));
        chk({ptr_x, ptr_y, ptr_z}, 48'h1B1A_1D1C_1F1E);
        rd(OFS_PTRXY, 32'h1D1C_1B1A);
        apb(1'b1, OFS_PTRZ, 32'h0000_0000);
        rd(OFS_PTRZ, 32'h0000_1F1E);
        rd(8'h40, 32'h0000_0000);
        chk(e, 1'b1);
        o = '0;
        o.rd = 5'd30;
        exec(o, 1'b0);
        chk(rd_word, 16'h1F1E);
        $display("test pointers done");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'h84, {24'h0, av[i]});
            apb(1'b1, 8'h88, {24'h0, bv[i]});
            o = '0;
            o.rd = 5'd1;
            o.rr = 5'd2;
            o.wb = WB_BYTE;
            exec(o, 1'b1);
            chk({rd_data, rr_data}, {av[i] + bv[i], bv[i]});
            chk(status_flags, exp_add(av[i], bv[i]));
        end
        $display("test alu done");
        o = '0;
        o.rd = 5'd24;
        o.wb = WB_WORD;
        o.wdata = 16'hBEEF;
        exec(o, 1'b0);
        chk(rd_word, 16'hBEEF);
        o = '0;
        o.rd = 5'd24;
        o.bit_store_op = 1'b1;
        o.bitsel = 3'd3;
        exec(o, 1'b0);
        chk(status_flags[6], 1'b1);
        o.rd = 5'd25;
        o.bit_store_op = 1'b0;
        o.bit_load_op = 1'b1;
        o.bitsel = 3'd0;
        exec(o, 1'b0);
        chk(rd_word, 16'hBFEF);
        $display("test word and bit copy done");
        dm(16'h0005, 1'b1, 8'h5A);
        rd(8'h94, 32'h0000_005A);
        dm(16'h005F, 1'b1, 8'h1C);
        chk({io_sel, dmem_is_reg, io_addr, dmem_rdata, status_flags}, 24'hBF_0C0C);
        $display("test data space done");
        step(1'b0);
        o = '0;
        o.sei = 1'b1;
        exec(o, 1'b0);
        step(1'b1);
        o = '0;
        o.return_from_interrupt_op = 1'b1;
        exec(o, 1'b0);
        chk(status_flags, 8'h8C);
        step(1'b0);
        step(1'b1);
        o = '0;
        o.sei = 1'b1;
        exec(o, 1'b0);
        o = '0;
        o.cli = 1'b1;
        exec(o, 1'b0);
        chk(status_flags[7], 1'b0);
        $display("test interrupts done");
        @(posedge pclk);
        store_program_memory_op <= 1'b1;
        spm_target <= 14'h0200;
        pc <= 14'h0100;
        #1 chk(spm_allow, 1'b0);
        @(posedge pclk);
        pc <= 14'h3000;
        call_op <= 1'b1;
        #1 chk(spm_allow, 1'b1);
        @(posedge pclk);
        call_op <= 1'b0;
        #1 chk({push_ret, ret_addr}, {1'b1, 16'h3000});
        chk(insn_ff, 16'hA5C3);
        $display("test program store done");
        end_sim();
    end
endmodule // test_cpu_status_and_register_file
